/* File: tb/host_model.sv */
// Host module model: drives enable, heartbeat and shutdown request.
// Assumes the bench sets the modes right after a rising edge.
module host_model (
  input wire logic clk_in, // Clock
  input wire logic enable_in, // Wanted enable level
  input wire logic alive_in, // Keep toggling heartbeat
  input wire logic answer_in, // Answer the flag with a request
  input wire logic hold_in, // Hold the request high regardless
  input wire logic flag_in, // Timeout flag seen
  output logic enable_out, // Enable pin
  output logic heartbeat_out, // Heartbeat pin
  output logic request_out // Shutdown request pin
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] cnt = 4'h0;

  initial
  begin
    enable_out = 1'b0;
    heartbeat_out = 1'b0;
    request_out = 1'b0;
  end

  always @(posedge clk_in)
  begin
    enable_out <= enable_in;
    cnt <= cnt + 4'h1;
    // Twelve clocks is well under the three-tick (30-clock) timeout that the bench's setting of 2 gives
    if (alive_in && cnt == 4'hB)
    begin
      heartbeat_out <= !heartbeat_out;
      cnt <= 4'h0;
    end
    request_out <= hold_in || (answer_in && flag_in);
  end
endmodule : host_model

/* File: tb/test_heartbeat_watchdog.sv */
// Bench: heartbeat watchdog with host model and APB master tasks.
// Assumes TICK_CYCLES of 10, so one second lasts ten clocks.
module test_heartbeat_watchdog;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, flag, pwr, run, sd, irq;
  logic en, hb, req;
  logic h_en = 1'b0;
  logic h_alive = 1'b0;
  logic h_ans = 1'b0;
  logic h_hold = 1'b0;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;

  always #5 clk = !clk;

  host_model i_host (.clk_in(clk), .enable_in(h_en), .alive_in(h_alive),
    .answer_in(h_ans), .hold_in(h_hold), .flag_in(flag), .enable_out(en),
    .heartbeat_out(hb), .request_out(req));

  heartbeat_watchdog #(.TICK_CYCLES(10)) i_dut (.sys_clk_in(clk),
    .arst_n_in(arst_n), .watchdog_enable_line_in(en),
    .heartbeat_line_in(hb), .shutdown_request_line_in(req),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timeout_flag_line_out(flag),
    .host_power_en_out(pwr), .host_run_out(run),
    .sd_alt_select_out(sd), .irq_out(irq));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    // Let the previous release settle instead of assigning psel twice
    if (psel)
      @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Counts clocks until flag (s=0) or power (s=1) reaches v
  task automatic wait_sig(input int s, input logic v, input int lim,
    output int n);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while ((s == 0 ? flag : pwr) !== v && n < lim);
  endtask : wait_sig

  // Checks that a count falls within lo..hi
  task automatic in_range(input int n, input int lo, input int hi);
    chk(32'(n >= lo && n <= hi), 32'h1);
  endtask : in_range

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    logic [7:0] a[5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
    logic [31:0] x[5] = '{32'h100, 32'h3C, 32'h3C, 32'h3C, 32'h5};
    logic [31:0] q;
    logic e;
    foreach (a[i])
    begin
      apb(1'b0, a[i], 32'h0, q, e);
      chk(q, x[i]);
    end
    apb(1'b0, 8'h40, 32'h0, q, e);
    chk(q, 32'h0);
    chk(32'(e), 32'h1);
    for (int i = 1; i < 5; i++)
      apb(1'b1, a[i], 32'h2, q, e);
    apb(1'b0, 8'h10, 32'h0, q, e);
    chk(q, 32'h2);
  endtask : t_regs

  task automatic t_quiet();
    int n;
    wait_sig(0, 1'b1, 100, n);
    chk(32'(flag), 32'h0);
    h_en <= 1'b1;
    h_alive <= 1'b1;
    wait_sig(0, 1'b1, 200, n);
    chk(32'(flag), 32'h0);
  endtask : t_quiet

  task automatic t_no_request();
    logic [31:0] q;
    logic e, s0, m0;
    int n;
    apb(1'b1, 8'h00, 32'h102, q, e);
    apb(1'b1, 8'h1C, 32'h0, q, e);
    s0 = sd;
    h_alive <= 1'b0;
    wait_sig(0, 1'b1, 100, n);
    in_range(n, 24, 35);
    wait_sig(1, 1'b0, 100, n);
    in_range(n, 35, 50);
    chk(32'(run), 32'h0);
    m0 = irq;
    apb(1'b1, 8'h1C, 32'h7, q, e);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'(!m0));
    wait_sig(1, 1'b1, 100, n);
    in_range(n, 16, 32);
    h_en <= 1'b0;
    @(posedge clk);
    chk(32'({flag, run, sd}), 32'({2'b01, !s0}));
    apb(1'b0, 8'h18, 32'h0, q, e);
    chk(q, 32'h7);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
  endtask : t_no_request

  task automatic t_request();
    logic [31:0] q;
    logic e;
    int n;
    h_ans <= 1'b1;
    h_en <= 1'b1;
    wait_sig(0, 1'b1, 100, n);
    wait_sig(1, 1'b0, 100, n);
    in_range(n, 18, 30);
    wait_sig(1, 1'b1, 100, n);
    h_en <= 1'b0;
    h_ans <= 1'b0;
    apb(1'b0, 8'h18, 32'h0, q, e);
    chk(q, 32'h7);
  endtask : t_request

  // Armed mode: supervision survives the enable line dropping
  task automatic t_armed();
    logic [31:0] q;
    logic e;
    apb(1'b1, 8'h00, 32'h1, q, e);
    h_hold <= 1'b1;
    h_en <= 1'b1;
    h_alive <= 1'b1;
    repeat (10) @(posedge clk);
    h_en <= 1'b0;
    repeat (20) @(posedge clk);
    apb(1'b0, 8'h14, 32'h0, q, e);
    chk(32'(q[26:24]), 32'(wdog_pkg::ST_WATCH));
    h_hold <= 1'b0;
    repeat (10) @(posedge clk);
    apb(1'b0, 8'h14, 32'h0, q, e);
    chk(32'(q[26:24]), 32'(wdog_pkg::ST_IDLE));
    h_alive <= 1'b0;
  endtask : t_armed

  initial
  begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_regs();
    t_quiet();
    t_no_request();
    t_request();
    t_armed();
    stop_test();
  end
endmodule : test_heartbeat_watchdog

/* File: tb/wdog_asserts.sv */
// Checker: port-level timing of the heartbeat watchdog.
// Assumes a seconds tick of at least ten clocks and waits of 1 s or more.
module wdog_asserts #(
  parameter int unsigned TICK_CYCLES = 10
) (
  input wire logic sys_clk_in, // Clock
  input wire logic arst_n_in, // Reset, active low
  input wire logic watchdog_enable_line_in, // Enable pin
  input wire logic shutdown_request_line_in, // Request pin
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic timeout_flag_line_out, // Timeout flag
  input wire logic host_power_en_out, // Host supplies
  input wire logic host_run_out // Host run line
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  a_run_with_power:
    assert property (host_run_out == host_power_en_out)
    else $error("run line and power disagree");
  a_off_needs_flag:
    assert property (!host_power_en_out |-> timeout_flag_line_out)
    else $error("power off without timeout flag");
  a_idle_when_off:
    assert property ((!watchdog_enable_line_in && !shutdown_request_line_in)
      [*8]
      |-> !$rose(timeout_flag_line_out))
    else $error("timeout while disabled");
  a_off_min_time:
    assert property ($fell(host_power_en_out) |-> !host_power_en_out [*8])
    else $error("power restored too soon");
  a_wait_before_off:
    assert property ($fell(host_power_en_out)
      |-> $past(timeout_flag_line_out, 8))
    else $error("power cut without shutdown wait");
  a_flag_until_restore:
    assert property ($fell(timeout_flag_line_out) |-> $rose(host_power_en_out))
    else $error("flag dropped before restore");
  a_ready_one_cycle:
    assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready not a single pulse");
  a_error_with_ready:
    assert property (pslverr |-> pready && psel && penable)
    else $error("error outside access phase");
endmodule : wdog_asserts

bind heartbeat_watchdog wdog_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .sys_clk_in(sys_clk_in),
  .arst_n_in(arst_n_in),
  .watchdog_enable_line_in(watchdog_enable_line_in),
  .shutdown_request_line_in(shutdown_request_line_in),
  .psel(psel),
  .penable(penable),
  .pready(pready),
  .pslverr(pslverr),
  .timeout_flag_line_out(timeout_flag_line_out),
  .host_power_en_out(host_power_en_out),
  .host_run_out(host_run_out)
);

/* File: verilog/heartbeat_watchdog.sv */
// Heartbeat watchdog and host power cycler with APB configuration.
// Assumes host GPIO lines arrive asynchronously; APB on sys_clk_in.
//
// Overview of operation
// - Watchdog idle after reset; supervises only while enable line is high, except in armed mode.
// - Any heartbeat edge restarts timer; timeout after configured 60 s plus 1 s of silence.
// - Timeout raises the timeout flag line and starts the shutdown sequence.
// - On request or 60 s fallback, wait 60 s more, then power-cycle.
// - Without a request the power cycle comes 120 s after timeout.
// - Power cycle removes host supplies and drives run line low together.
// - Optionally swap boot SD card after N consecutive timeouts.
// - Timeout, waits and control modes are configurable; defaults as given.
// - Supplies stay off for the configured power-off time, default 5 s.
// - In armed mode, watchdog stays active while shutdown request is high.
module heartbeat_watchdog #(
  parameter int unsigned TICK_CYCLES = wdog_pkg::TICK_CYCLES
) (
  input wire logic sys_clk_in, // 100 MHz clock
  input wire logic arst_n_in, // Async reset, active low
  input wire logic watchdog_enable_line_in, // Host enable pin
  input wire logic heartbeat_line_in, // Host heartbeat pin
  input wire logic shutdown_request_line_in, // Host shutdown pin
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  output logic timeout_flag_line_out, // High on watchdog timeout
  output logic host_power_en_out, // High while host supplies on
  output logic host_run_out, // Host run line, low resets
  output logic sd_alt_select_out, // Boot from alternate card
  output logic irq_out // Level interrupt
);

  // ****************************************
  // Reset release and input synchronisers
  // ****************************************
  logic [1:0] rst_sync;
  logic rst_n;
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic hb_prev;

  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
      hb_prev <= 1'b0;
    end
    else
    begin
      pin_meta <= {shutdown_request_line_in, heartbeat_line_in,
                   watchdog_enable_line_in};
      pin_sync <= pin_meta;
      hb_prev <= pin_sync[1];
    end
  end

  logic wd_en;
  logic hb_edge;
  logic shdn_req;
  assign wd_en = pin_sync[0];
  assign shdn_req = pin_sync[2];
  assign hb_edge = pin_sync[1] ^ hb_prev;

  // ****************************************
  // Configuration registers
  // ****************************************
  localparam int IRQ_W_L = wdog_pkg::IRQ_W;
  wdog_pkg::wd_cfg_t cfg;
  logic [31:0] ctrl;
  logic [15:0] timeout_s;
  logic [15:0] fallback_s;
  logic [15:0] wait_s;
  logic [15:0] off_s;
  logic [IRQ_W_L-1:0] irq_mask;
  logic wr_en;
  logic rd_en;
  logic addr_ok;

  assign wr_en = psel && penable && pwrite && pready;
  assign rd_en = psel && penable && !pwrite && pready;

  // One driver for the whole struct; timing fields live in their own flops
  assign cfg = {ctrl[wdog_pkg::CTRL_ARM_MODE], ctrl[wdog_pkg::CTRL_SWAP_EN],
                ctrl[wdog_pkg::CTRL_SWAP_LSB +: wdog_pkg::CTRL_SWAP_W],
                timeout_s, fallback_s, wait_s, off_s};

  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl <= wdog_pkg::CTRL_RESET;
      timeout_s <= 16'(wdog_pkg::HB_TIMEOUT_S);
      fallback_s <= 16'(wdog_pkg::SHDN_FALLBACK_S);
      wait_s <= 16'(wdog_pkg::SHDN_WAIT_S);
      off_s <= 16'(wdog_pkg::POWER_OFF_S);
      irq_mask <= '0;
    end
    else if (wr_en)
    begin
      unique case (paddr)
        wdog_pkg::ADDR_CTRL: ctrl <= {16'h0000, pwdata[15:0]};
        wdog_pkg::ADDR_TIMEOUT: timeout_s <= pwdata[15:0];
        wdog_pkg::ADDR_FALLBACK: fallback_s <= pwdata[15:0];
        wdog_pkg::ADDR_WAIT: wait_s <= pwdata[15:0];
        wdog_pkg::ADDR_OFFTIME: off_s <= pwdata[15:0];
        wdog_pkg::ADDR_IRQ_MASK: irq_mask <= pwdata[IRQ_W_L-1:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // Seconds tick
  // ****************************************
  logic tick;
  logic tick_restart;

  sec_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_n),
    .restart_in(tick_restart),
    .tick_out(tick)
  );

  // ****************************************
  // Watchdog sequencer
  // ****************************************
  wdog_pkg::wd_state_t state;
  logic [15:0] secs;
  logic [7:0] consec;
  logic active;
  logic [IRQ_W_L-1:0] events;

  // Once supervising, armed mode keeps it alive while the request is high,
  // even if the enable line drops during the host's shutdown
  assign active = wd_en
                  || (cfg.arm_mode && shdn_req
                      && state == wdog_pkg::ST_WATCH);
  // Restarting the prescaler on every heartbeat edge in ST_WATCH makes the timeout
  // exact to within one clock instead of one second
  assign tick_restart = (state == wdog_pkg::ST_WATCH) && hb_edge;

  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= wdog_pkg::ST_IDLE;
      secs <= 16'h0000;
      consec <= 8'h00;
      timeout_flag_line_out <= 1'b0;
      host_power_en_out <= 1'b1;
      host_run_out <= 1'b1;
      sd_alt_select_out <= 1'b0;
      events <= '0;
    end
    else
    begin
      events <= '0;
      unique case (state)
        wdog_pkg::ST_IDLE:
        begin
          secs <= 16'h0000;
          if (active)
            state <= wdog_pkg::ST_WATCH;
        end
        wdog_pkg::ST_WATCH:
        begin
          if (!active)
            state <= wdog_pkg::ST_IDLE;
          else if (hb_edge)
          begin
            secs <= 16'h0000;
            consec <= 8'h00;
          end
          else if (tick)
          begin
            if (secs >= cfg.timeout_s)
            begin
              timeout_flag_line_out <= 1'b1;
              events[wdog_pkg::IRQ_TIMEOUT] <= 1'b1;
              consec <= consec + 8'h01;
              secs <= 16'h0000;
              state <= wdog_pkg::ST_WAIT_REQ;
            end
            else
              secs <= secs + 16'h0001;
          end
        end
        wdog_pkg::ST_WAIT_REQ:
        begin
          if (shdn_req || (tick && secs + 16'h0001 >= cfg.fallback_s))
          begin
            secs <= 16'h0000;
            state <= wdog_pkg::ST_SHDN_WAIT;
          end
          else if (tick)
            secs <= secs + 16'h0001;
        end
        wdog_pkg::ST_SHDN_WAIT:
        begin
          if (tick && secs + 16'h0001 >= cfg.wait_s)
          begin
            host_power_en_out <= 1'b0;
            host_run_out <= 1'b0;
            events[wdog_pkg::IRQ_CYCLE] <= 1'b1;
            secs <= 16'h0000;
            state <= wdog_pkg::ST_POWER_OFF;
            if (cfg.swap_en && consec >= cfg.swap_count
                && cfg.swap_count != 8'h00)
            begin
              sd_alt_select_out <= !sd_alt_select_out;
              events[wdog_pkg::IRQ_SWAP] <= 1'b1;
              consec <= 8'h00;
            end
          end
          else if (tick)
            secs <= secs + 16'h0001;
        end
        wdog_pkg::ST_POWER_OFF:
        begin
          if (tick && secs + 16'h0001 >= cfg.off_s)
          begin
            host_power_en_out <= 1'b1;
            host_run_out <= 1'b1;
            timeout_flag_line_out <= 1'b0;
            secs <= 16'h0000;
            state <= wdog_pkg::ST_IDLE;
          end
          else if (tick)
            secs <= secs + 16'h0001;
        end
        default: state <= wdog_pkg::ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Interrupt status, read clears
  // ****************************************
  logic [IRQ_W_L-1:0] irq_stat;
  logic stat_rd;
  assign stat_rd = rd_en && paddr == wdog_pkg::ADDR_IRQ_STAT;

  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_stat <= '0;
      irq_out <= 1'b0;
    end
    else
    begin
      // A new event in the clearing cycle survives the read
      irq_stat <= (stat_rd ? '0 : irq_stat) | events;
      irq_out <= |(((stat_rd ? '0 : irq_stat) | events) & irq_mask);
    end
  end

  // ****************************************
  // APB read path: no wait states, answer registered
  // ****************************************
  always_comb
  begin
    unique case (paddr)
      wdog_pkg::ADDR_CTRL, wdog_pkg::ADDR_TIMEOUT, wdog_pkg::ADDR_FALLBACK,
      wdog_pkg::ADDR_WAIT, wdog_pkg::ADDR_OFFTIME, wdog_pkg::ADDR_STATUS,
      wdog_pkg::ADDR_IRQ_STAT, wdog_pkg::ADDR_IRQ_MASK: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite)
      begin
        unique case (paddr)
          wdog_pkg::ADDR_CTRL: prdata <= ctrl;
          wdog_pkg::ADDR_TIMEOUT: prdata <= {16'h0000, cfg.timeout_s};
          wdog_pkg::ADDR_FALLBACK: prdata <= {16'h0000, cfg.fallback_s};
          wdog_pkg::ADDR_WAIT: prdata <= {16'h0000, cfg.wait_s};
          wdog_pkg::ADDR_OFFTIME: prdata <= {16'h0000, cfg.off_s};
          wdog_pkg::ADDR_STATUS:
            prdata <= {5'h00, state, consec, secs};
          wdog_pkg::ADDR_IRQ_STAT:
            prdata <= {29'h0000_0000, irq_stat};
          wdog_pkg::ADDR_IRQ_MASK:
            prdata <= {29'h0000_0000, irq_mask};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule : heartbeat_watchdog

/* File: verilog/sec_tick.sv */
// Seconds prescaler: one-cycle pulse every TICK_CYCLES clocks.
// Assumes a synchronised active-low reset already released cleanly.
module sec_tick #(
  parameter int unsigned TICK_CYCLES = wdog_pkg::TICK_CYCLES
) (
  input wire logic clk_in, // System clock
  input wire logic rst_n_in, // Synchronised reset, active low
  input wire logic restart_in, // Realign the second boundary
  output logic tick_out // One-cycle pulse per second
);

  logic [31:0] count;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      count <= 32'h0000_0000;
      tick_out <= 1'b0;
    end
    else if (restart_in || count == TICK_CYCLES - 1)
    begin
      count <= 32'h0000_0000;
      tick_out <= !restart_in;
    end
    else
    begin
      count <= count + 32'h0000_0001;
      tick_out <= 1'b0;
    end
  end

endmodule : sec_tick

/* File: verilog/wdog_pkg.sv */
// Package: constants, types and register map of the heartbeat watchdog.
// Assumes a single 100 MHz clock domain and an APB register port.
package wdog_pkg;

  // ****************************************
  // Clock and time base
  // ****************************************
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned TICK_CYCLES = CLK_HZ;
  localparam int unsigned HB_TIMEOUT_S = 60;
  localparam int unsigned SHDN_FALLBACK_S = 60;
  localparam int unsigned SHDN_WAIT_S = 60;
  localparam int unsigned POWER_OFF_S = 5;
  localparam int unsigned SWAP_COUNT_DEF = 1;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TIMEOUT = 8'h04;
  localparam logic [7:0] ADDR_FALLBACK = 8'h08;
  localparam logic [7:0] ADDR_WAIT = 8'h0C;
  localparam logic [7:0] ADDR_OFFTIME = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C;

  // CTRL fields
  localparam int CTRL_ARM_MODE = 0;
  localparam int CTRL_SWAP_EN = 1;
  localparam int CTRL_SWAP_LSB = 8;
  localparam int CTRL_SWAP_W = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0100;

  // Interrupt event bits
  localparam int IRQ_TIMEOUT = 0;
  localparam int IRQ_CYCLE = 1;
  localparam int IRQ_SWAP = 2;
  localparam int IRQ_W = 3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WATCH = 3'b001,
    ST_WAIT_REQ = 3'b010,
    ST_SHDN_WAIT = 3'b011,
    ST_POWER_OFF = 3'b100
  } wd_state_t;

  typedef struct packed {
    logic arm_mode;
    logic swap_en;
    logic [7:0] swap_count;
    logic [15:0] timeout_s;
    logic [15:0] fallback_s;
    logic [15:0] wait_s;
    logic [15:0] off_s;
  } wd_cfg_t;

endpackage : wdog_pkg
